// ---- external_control_io_port.sv ----
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns

// Summary of operation
// - The power indication output is high while the power source is on.
// - The output-state indication is high while the output is enabled.
// - The limiter indication is high while any of the four limiters acts.
// - The busy indication is high while the internal software is busy.
// - Each control input acts only on a high-to-low transition.
// - Every status output is driven continuously, never left floating.
// - Two sequence sync outputs let an outside party follow the sequence.
module external_control_io_port
	import ext_io_pkg::*;
(
	input  wire logic        core_clk,     // system clock, 25 MHz
	input  wire logic        reset,        // async reset, active high
	input  wire logic        psel,         // apb select
	input  wire logic        penable,      // apb access phase
	input  wire logic        pwrite,       // apb direction
	input  wire logic [11:0] paddr,        // apb byte address
	input  wire logic [31:0] pwdata,       // apb write data
	output logic      [31:0] prdata,       // apb read data
	output logic             pready,       // apb ready
	output logic             pslverr,      // apb error
	input  wire logic [6:0]  ctrlIn,       // control input pins
	output status_pins_s     statusPins,   // status output pins
	output logic      [6:0]  actionPulse,  // one-cycle action pulses
	output logic             irq           // level interrupt
);

	// ****************************************
	// signals
	// ****************************************
	logic [6:0]  syncA_reg;
	logic [6:0]  syncB_reg;
	logic [6:0]  prev_reg;
	logic [13:0] ctrl_reg;
	logic [6:0]  event_reg;
	logic [6:0]  event_next;
	logic [6:0]  mask_reg;
	logic        outEn_reg;
	seq_state_e  seq_reg;
	seq_state_e  seq_next;
	status_pins_s status_reg;
	status_pins_s status_next;
	logic [31:0] rdata_next;
	wire  [6:0]  fall;
	wire         access;
	wire         wrEn;
	wire         rdEn;
	wire         hitCtrl;
	wire         hitStatus;
	wire         hitEvent;
	wire         hitMask;
	wire         hitPins;
	wire         mapped;
	wire         limitAny;

	// named strobes, pulses, state decode and read words
	wire         wrCtrl;
	wire         wrEvent;
	wire         wrMask;
	wire  [6:0]  evClear;
	wire         outOffFell;
	wire         outOnFell;
	wire         startFell;
	wire         stopFell;
	wire         holdFell;
	wire         seqRunning;
	wire         seqHeld;
	wire  [31:0] rdCtrl;
	wire  [31:0] rdStatus;
	wire  [31:0] rdEvent;
	wire  [31:0] rdMask;
	wire  [31:0] rdPins;

	// ****************************************
	// control input synchroniser and edge detect
	// ****************************************

	// two flops, then a third stage for the previous level
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			syncA_reg <= PIN_IDLE[6:0];
			syncB_reg <= PIN_IDLE[6:0];
			prev_reg  <= PIN_IDLE[6:0];
		end else begin
			syncA_reg <= ctrlIn;
			syncB_reg <= syncA_reg;
			prev_reg  <= syncB_reg;
		end
	end

	// ****************************************
	// falling edge detect
	// ****************************************

	// high last cycle, low now; idle-high lines never fire
	assign fall = prev_reg & ~syncB_reg;
	assign actionPulse = fall;

	// ****************************************
	// named action pulses
	// ****************************************

	// one wire per pin action, read by the state below
	assign outOffFell = fall[EV_OUT_OFF];
	assign outOnFell  = fall[EV_OUT_ON];
	assign startFell  = fall[EV_SEQ_START];
	assign stopFell   = fall[EV_SEQ_STOP];
	assign holdFell   = fall[EV_SEQ_HOLD];
	// branch lines only raise a pulse and an event bit

	// ****************************************
	// apb decode
	// ****************************************

	// address match against one register offset
	function automatic logic addrHit(input logic [11:0] addr,
	                                 input logic [11:0] offset);
		return addr == offset;
	endfunction

	// access phase and direction
	assign access    = psel & penable;
	assign wrEn      = access & pwrite;
	assign rdEn      = access & ~pwrite;

	// one match per register, zero wait states
	assign hitCtrl   = addrHit(paddr, ADDR_CTRL);
	assign hitStatus = addrHit(paddr, ADDR_STATUS);
	assign hitEvent  = addrHit(paddr, ADDR_EVENT);
	assign hitMask   = addrHit(paddr, ADDR_MASK);
	assign hitPins   = addrHit(paddr, ADDR_PINS);
	assign mapped    = hitCtrl | hitStatus | hitEvent | hitMask | hitPins;
	assign pready    = 1'b1;
	assign pslverr   = access & ~mapped;

	// write strobes; unmapped writes touch nothing
	assign wrCtrl    = wrEn & hitCtrl;
	assign wrEvent   = wrEn & hitEvent;
	assign wrMask    = wrEn & hitMask;

	// ****************************************
	// read data
	// ****************************************

	// each register gated by its own match
	assign rdCtrl    = hitCtrl   ? {18'h0, ctrl_reg}   : 32'h0;
	assign rdStatus  = hitStatus ? {24'h0, status_reg} : 32'h0;
	assign rdEvent   = hitEvent  ? {25'h0, event_reg}  : 32'h0;
	assign rdMask    = hitMask   ? {25'h0, mask_reg}   : 32'h0;
	assign rdPins    = hitPins   ? {25'h0, syncB_reg}  : 32'h0;

	// matches are exclusive, so an or of the gated words selects
	assign rdata_next = rdCtrl | rdStatus | rdEvent | rdMask | rdPins;
	assign prdata     = rdEn ? rdata_next : 32'h0000_0000;

	// ****************************************
	// control register
	// ****************************************

	// software-set power, busy, limiter and spare levels
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl_reg <= CTRL_RESET;
		end else if (wrCtrl) begin
			ctrl_reg <= pwdata[13:0];
		end
	end

	// ****************************************
	// output enable and sequence state
	// ****************************************

	// output on/off by pin edges; off wins if both fall together
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			outEn_reg <= 1'b0;
		end else if (outOffFell) begin
			outEn_reg <= 1'b0;
		end else if (outOnFell) begin
			outEn_reg <= 1'b1;
		end else if (wrCtrl) begin
			outEn_reg <= pwdata[CTRL_OUT_BIT];
		end
	end

	// ****************************************
	// sequence state
	// ****************************************

	// stop beats hold in run and start in hold, start beats stop in idle; branches do not move the state
	always_comb begin
		seq_next = seq_reg;
		case (seq_reg)
			SEQ_IDLE: begin
				if (startFell) begin
					seq_next = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (stopFell) begin
					seq_next = SEQ_IDLE;
				end else if (holdFell) begin
					seq_next = SEQ_HOLD;
				end
			end
			SEQ_HOLD: begin
				if (stopFell) begin
					seq_next = SEQ_IDLE;
				end else if (startFell) begin
					seq_next = SEQ_RUN;
				end
			end
			default: seq_next = SEQ_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			seq_reg <= SEQ_IDLE;
		end else begin
			seq_reg <= seq_next;
		end
	end

	// state decode for the sync pins
	assign seqRunning = seq_reg == SEQ_RUN;
	assign seqHeld    = seq_reg == SEQ_HOLD;

	// ****************************************
	// status pins
	// ****************************************

	// any of peak+, peak-, average current or power limiter
	assign limitAny = |ctrl_reg[CTRL_LIM_LSB +: 4];

	// next value of every indication line
	always_comb begin
		status_next.powerOn     = ctrl_reg[CTRL_PWR_BIT];
		status_next.outputOn    = outEn_reg;
		status_next.limitActive = limitAny;
		status_next.busy        = ctrl_reg[CTRL_BUSY_BIT];
		// sync pins: software pattern or live sequence state
		status_next.seqSync0    = ctrl_reg[CTRL_SYNC_LSB] |
		                          seqRunning;
		status_next.seqSync1    = ctrl_reg[CTRL_SYNC_LSB + 1] |
		                          seqHeld;
		status_next.spare0      = ctrl_reg[CTRL_SPARE_LSB];
		status_next.spare1      = ctrl_reg[CTRL_SPARE_LSB + 1];
	end

	// ****************************************
	// status register
	// ****************************************

	// registered, always driven from reset onward
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			statusPins <= '0;
		end else begin
			statusPins <= status_next;
		end
	end

	// read-back copy of the pins
	assign status_reg = statusPins;

	// ****************************************
	// interrupt status and mask
	// ****************************************

	// clear vector from a write of ones
	assign evClear    = wrEvent ? pwdata[6:0] : 7'h00;

	// set wins over write-one-to-clear
	assign event_next = (event_reg & ~evClear) | fall;

	// ****************************************
	// event and mask registers
	// ****************************************

	// sticky events and the mask beside them
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			event_reg <= 7'h00;
			mask_reg  <= MASK_RESET;
		end else begin
			event_reg <= event_next;
			if (wrMask) begin
				mask_reg <= pwdata[6:0];
			end
		end
	end

	// level output, high while an unmasked bit is set
	assign irq = |(event_reg & mask_reg);

endmodule

// ---- ext_io_pkg.sv ----
package ext_io_pkg;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [11:0] ADDR_CTRL    = 12'h000;
	localparam logic [11:0] ADDR_STATUS  = 12'h004;
	localparam logic [11:0] ADDR_EVENT   = 12'h008;
	localparam logic [11:0] ADDR_MASK    = 12'h00c;
	localparam logic [11:0] ADDR_PINS    = 12'h010;

	// ****************************************
	// field positions
	// ****************************************
	localparam int CTRL_PWR_BIT   = 0;
	localparam int CTRL_OUT_BIT   = 1;
	localparam int CTRL_BUSY_BIT  = 2;
	localparam int CTRL_LIM_LSB   = 4;
	localparam int CTRL_SYNC_LSB  = 8;
	localparam int CTRL_SPARE_LSB = 12;

	// event bit positions, one per control input
	localparam int EV_OUT_OFF   = 0;
	localparam int EV_OUT_ON    = 1;
	localparam int EV_SEQ_START = 2;
	localparam int EV_SEQ_STOP  = 3;
	localparam int EV_SEQ_HOLD  = 4;
	localparam int EV_BRANCH1   = 5;
	localparam int EV_BRANCH2   = 6;
	localparam int NUM_CTRL_IN  = 7;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [13:0] CTRL_RESET = 14'h0000;
	localparam logic [6:0]  MASK_RESET = 7'h00;
	localparam logic [7:0]  PIN_IDLE   = 8'hff;

	// status outputs gathered together
	typedef struct packed {
		logic       spare1;
		logic       spare0;
		logic       seqSync1;
		logic       seqSync0;
		logic       busy;
		logic       limitActive;
		logic       outputOn;
		logic       powerOn;
	} status_pins_s;

	// sequence state reported on the sync outputs
	typedef enum {
		SEQ_IDLE,
		SEQ_RUN,
		SEQ_HOLD
	} seq_state_e;

endpackage

// ---- ext_io_assertions.sv ----
`timescale 1ns/1ns
// ****************************************
// port checker
// ****************************************
module ext_io_checker
	import ext_io_pkg::*;
(
	input wire logic         core_clk,    // clock
	input wire logic         reset,       // reset
	input wire logic         psel,        // apb select
	input wire logic         penable,     // apb access
	input wire logic         pwrite,      // apb direction
	input wire logic  [11:0] paddr,       // apb address
	input wire logic  [31:0] pwdata,      // apb write data
	input wire logic  [31:0] prdata,      // apb read data
	input wire logic         pready,      // apb ready
	input wire logic         pslverr,     // apb error
	input wire logic  [6:0]  ctrlIn,      // control pins
	input wire status_pins_s statusPins,  // status pins
	input wire logic  [6:0]  actionPulse, // action pulses
	input wire logic         irq          // interrupt
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// access decode and written control fields
	wire       acc    = psel && penable;
	wire       ctrlWr = acc && pwrite && paddr == ADDR_CTRL;
	wire       mapped = paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_EVENT,
		ADDR_MASK, ADDR_PINS};
	wire [2:0] ctrlVal = {|pwdata[7:4], pwdata[2], pwdata[0]};
	// ****************************************
	// assertions
	// ****************************************
	apb_ready_a: assert property (psel |-> pready)
		else $error("pready low");
	slv_err_a: assert property (acc |-> pslverr == !mapped)
		else $error("pslverr wrong");
	rdata_idle_a: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
		else $error("prdata not idle");
	status_read_a: assert property (
		acc && !pwrite && paddr == ADDR_STATUS |-> prdata[7:0] == statusPins)
		else $error("status read");
	ctrl_mirror_a: assert property (
		ctrlWr |-> ##2 {statusPins.limitActive, statusPins.busy,
		statusPins.powerOn} == $past(ctrlVal, 2))
		else $error("status not from control");
	edge_pulse_a: assert property (
		actionPulse == ($past(ctrlIn, 3) & ~$past(ctrlIn, 2)))
		else $error("pulse without fall");
	out_on_a: assert property (
		actionPulse[EV_OUT_ON] && !actionPulse[EV_OUT_OFF]
		|-> ##2 statusPins.outputOn) else $error("output not on");
	out_off_a: assert property (actionPulse[EV_OUT_OFF]
		|-> ##2 !statusPins.outputOn) else $error("output not off");
	seq_run_a: assert property (actionPulse[EV_SEQ_START]
		&& !actionPulse[EV_SEQ_STOP] |-> ##2 statusPins.seqSync0)
		else $error("sequence not run");
	cover property (actionPulse[EV_SEQ_HOLD]);
	cover property (ctrlWr);
	cover property (acc && pslverr);
	cover property (irq);
endmodule

bind external_control_io_port ext_io_checker chk (
	.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .ctrlIn(ctrlIn),
	.statusPins(statusPins), .actionPulse(actionPulse), .irq(irq));

// ---- ctrl_pin_driver.sv ----
`timescale 1ns/1ns
// ****************************************
// outside controller on the control pins
// ****************************************
module ctrl_pin_driver (
	input  wire logic       core_clk, // system clock
	output logic      [6:0] ctrlIn    // control pins
);
	// open lines rest high
	initial ctrlIn = 7'h7f;
	// pull one line low for three cycles, then release
	task automatic strike(input int i);
		@(posedge core_clk);
		ctrlIn[i] <= 1'b0;
		repeat (3) @(posedge core_clk);
		ctrlIn[i] <= 1'b1;
	endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ns
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin \
	miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, s); \
	end end
module tb import ext_io_pkg::*;;
	logic         core_clk = 1'b0, reset = 1'b1, err;
	logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic  [11:0] paddr = 12'h0;
	logic  [31:0] pwdata = 32'h0, prdata, rd;
	logic         pready, pslverr, irq;
	logic  [6:0]  ctrlIn, actionPulse;
	status_pins_s statusPins;
	int           miscompares = 0, n_compared = 0, cyc = 0;
	int           pinSeq [15] = '{0, 1, 2, 3, 4, 5, 6, 2, 4, 0, 2, 4, 3,
		2, 4};
	logic  [7:0]  expSt [15] = '{8'h00, 8'h02, 8'h12, 8'h02, 8'h02,
		8'h02, 8'h02, 8'h12, 8'h22, 8'h20, 8'h10, 8'h20, 8'h00, 8'h10,
		8'h20};
	// design and outside controller
	external_control_io_port uut (.core_clk(core_clk), .reset(reset),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ctrlIn(ctrlIn), .statusPins(statusPins),
		.actionPulse(actionPulse), .irq(irq));
	ctrl_pin_driver drv (.core_clk(core_clk), .ctrlIn(ctrlIn));
	// clock and hang guard
	always #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			give_verdict();
		end
	end
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge core_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task give_verdict;
		if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		for (int a = 0; a < 5; a++) begin
			apb(1'b0, 12'(a * 4), 32'h0);
			`CHK("reset", (a == 4) ? 32'h7f : 32'h0, rd);
		end
		for (int i = 0; i < 15; i++) begin
			drv.strike(pinSeq[i]);
			repeat (6) @(posedge core_clk);
			apb(1'b0, ADDR_STATUS, 32'h0);
			`CHK("status", {24'h0, expSt[i]}, rd);
			`CHK("pins", expSt[i], statusPins);
			if (i == 0) begin
				`CHK("masked irq", 1'b0, irq);
				apb(1'b1, ADDR_MASK, 32'h7f);
				@(posedge core_clk);
				`CHK("irq", 1'b1, irq);
			end
		end
		apb(1'b0, ADDR_EVENT, 32'h0);
		`CHK("events", 32'h7f, rd);
		apb(1'b1, ADDR_EVENT, 32'h7f);
		apb(1'b0, ADDR_EVENT, 32'h0);
		`CHK("cleared", 32'h0, rd);
		`CHK("irq off", 1'b0, irq);
		for (int j = 0; j < 4; j++) begin
			apb(1'b1, ADDR_CTRL, 32'h3005 | (32'h10 << j));
			repeat (2) @(posedge core_clk);
			`CHK("limit", 8'hed, statusPins);
		end
		apb(1'b1, ADDR_CTRL, 32'h2);
		repeat (2) @(posedge core_clk);
		`CHK("sw output", 8'h22, statusPins);
		apb(1'b1, ADDR_CTRL, 32'h300);
		repeat (2) @(posedge core_clk);
		`CHK("sync force", 8'h30, statusPins);
		apb(1'b1, 12'h014, 32'hffffffff);
		`CHK("bad write", 1'b1, err);
		apb(1'b0, 12'h014, 32'h0);
		`CHK("bad read", 33'h100000000, {err, rd});
		give_verdict();
	end
endmodule
